//--- sram_host_consts.svh
// Timing constants and behaviour notes for the SRAM host controller
// Notes on behaviour
// - Data held stable around write-ending edge
// - Strobe low at least setup plus float
// - Host never drives while memory drives
// - Read: address valid at CE fall, WE high
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_PS           20000
`define ADDRESS_ACCESS_DELAY_PS 15000
`define DATA_SETUP_TIME_PS      8000
`define STROBE_TO_FLOAT_DELAY_PS 8000
`define WE_PULSE_MIN_PS         12000
`define CE_HIGH_TO_FLOAT_PS     8000
`define CYC_UP(t) (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ACCESS_CYCLES   (`CYC_UP(`ADDRESS_ACCESS_DELAY_PS) + 1)
`define WE_LOW_CYCLES \
   `CYC_UP(`DATA_SETUP_TIME_PS + `STROBE_TO_FLOAT_DELAY_PS)
`define TURN_CYCLES     `CYC_UP(`CE_HIGH_TO_FLOAT_PS)
`define IDLE_PINS_N     2'h3
`endif

//--- sram_host_pkg.sv
// Types shared by the SRAM host controller
package sram_host_pkg;
   typedef struct packed {
      logic        write;
      logic [1:0]  lane_n;
      logic [17:0] addr;
      logic [15:0] wdata;
   } sram_req_t;
   typedef struct packed {
      logic [15:0] rdata;
      logic        corrected;
   } sram_rsp_t;
   typedef struct packed {
      logic        chip_sel_n;
      logic        out_gate_n;
      logic        write_n;
      logic        high_byte_lane_n;
      logic        low_byte_lane_n;
      logic [17:0] addr;
   } sram_ctl_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_WSETUP, ST_WLOW, ST_WEND, ST_TURN
   } sram_state_t;
endpackage

//--- sram_cycle_timer.sv
// Down counter that marks the end of a timed bus phase
`timescale 1ns/100ps
module sram_cycle_timer #(
   parameter int WIDTH = 4
) (
   input  wire logic             core_clk, // System clock
   input  wire logic             reset,    // Sync reset, active high
   input  wire logic             load,     // Load new count
   input  wire logic [WIDTH-1:0] count,    // Cycles to run
   output logic                  done      // Count exhausted
);
   logic [WIDTH-1:0] cnt_q;
   if (WIDTH < 2) begin : g_bad_width
      $error("sram_cycle_timer: WIDTH too small");
   end
   // Pure register decode, so a load that depends on done forms no loop
   assign done = (cnt_q == '0);
   always_ff @(posedge core_clk) begin
      if (reset) cnt_q <= '0;
      else if (load) cnt_q <= count;
      else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
   end
endmodule

//--- sram_host.sv
// Host controller that drives an asynchronous 16-bit ECC SRAM
`timescale 1ns/100ps
`include "sram_host_consts.svh"
module sram_host #(
   parameter int ADDR_W = 18, // Word address width
   parameter int DATA_W = 16  // Data bus width
) (
   input  wire logic                   core_clk,   // System clock
   input  wire logic                   reset,      // Sync reset
   input  wire logic                   req_valid,  // Request present
   output logic                        req_ready,  // Request taken
   input  wire sram_host_pkg::sram_req_t req,      // Request contents
   output logic                        rsp_valid,  // Read data pulse
   output sram_host_pkg::sram_rsp_t    rsp,        // Read data, flag
   output logic                        wr_done,    // Write end pulse
   output sram_host_pkg::sram_ctl_t    ctl,        // Control pins
   input  wire logic [DATA_W-1:0]      dq_in,      // Data pins in
   output logic [DATA_W-1:0]           dq_out,     // Data pins out
   output logic [1:0]                  dq_oe_n,    // Lane enables, low
   input  wire logic                   flag_in     // Corrected flag pin
);
   import sram_host_pkg::*;

   localparam int ACC_C  = `ACCESS_CYCLES;
   localparam int WLOW_C = (`WE_LOW_CYCLES > `CYC_UP(`WE_PULSE_MIN_PS))
                         ? `WE_LOW_CYCLES : `CYC_UP(`WE_PULSE_MIN_PS);
   localparam int TURN_C = `TURN_CYCLES;
   // Every control pin level the controller takes out of reset
   localparam sram_ctl_t CTL_IDLE = '{chip_sel_n: 1'b1, out_gate_n: 1'b1,
                                      write_n: 1'b1, high_byte_lane_n: 1'b1,
                                      low_byte_lane_n: 1'b1, addr: '0};

   // The pin shape is fixed by the memory; the phase timer is four bits
   if (ADDR_W != 18) begin : g_bad_addr
      $error("sram_host: address bus must be 18 bits");
   end
   if (DATA_W != 16) begin : g_bad_data
      $error("sram_host: data bus must be 16 bits");
   end
   if (ACC_C > 15 || WLOW_C > 15 || TURN_C > 15) begin : g_bad_count
      $error("sram_host: a phase count does not fit the timer");
   end

   sram_state_t   state_q, state_d;
   sram_ctl_t     ctl_q, ctl_d;
   logic [15:0]   wdata_q;
   logic [1:0]    drive_n_q, drive_n_d;
   logic [15:0]   dq_s1_q, dq_s2_q;
   logic          flag_s1_q, flag_s2_q;
   sram_rsp_t     rsp_q;
   logic          rsp_valid_q, wr_done_q;
   logic          tmr_load;
   logic [3:0]    tmr_count;
   logic          tmr_done;

   // Pin inputs come from another timing domain: two flops first
   // The first flop may go metastable; only the second is read
   always_ff @(posedge core_clk) begin
      dq_s1_q   <= dq_in;
      dq_s2_q   <= dq_s1_q;
      flag_s1_q <= flag_in;
      flag_s2_q <= flag_s1_q;
   end

   sram_cycle_timer #(.WIDTH(4)) u_timer (
      .core_clk (core_clk),
      .reset    (reset),
      .load     (tmr_load),
      .count    (tmr_count),
      .done     (tmr_done)
   );

   // State decode, shared by the handshake and the result registers
   wire in_idle   = (state_q == ST_IDLE);
   wire in_read   = (state_q == ST_READ);
   wire in_wend   = (state_q == ST_WEND);
   wire accept    = req_valid && in_idle;
   // Taken from the timer register alone: the load below depends on it
   wire phase_end = tmr_done;
   assign req_ready = in_idle;

   // A timer load of N keeps its phase for N+1 cycles. Reads add one
   // cycle of slack so the two-flop synchroniser has settled the data;
   // writes raise the gate before the lanes drive, and a turn phase
   // after each transfer lets the memory float before the next one.
   always_comb begin
      state_d   = state_q;
      ctl_d     = ctl_q;
      drive_n_d = drive_n_q;
      tmr_load  = 1'b0;
      tmr_count = 4'h0;
      case (state_q)
         ST_IDLE: begin
            if (accept) begin
               // Address settles together with select
               ctl_d.addr             = req.addr;
               ctl_d.chip_sel_n       = 1'b0;
               ctl_d.high_byte_lane_n = req.lane_n[1];
               ctl_d.low_byte_lane_n  = req.lane_n[0];
               tmr_load = 1'b1;
               if (req.write) begin
                  // Gate high so memory floats before we drive
                  ctl_d.out_gate_n = 1'b1;
                  ctl_d.write_n    = 1'b1;
                  tmr_count = 4'(TURN_C);
                  state_d   = ST_WSETUP;
               end else begin
                  ctl_d.out_gate_n = 1'b0;
                  ctl_d.write_n    = 1'b1;
                  tmr_count = 4'(ACC_C);
                  state_d   = ST_READ;
               end
            end
         end
         ST_READ: begin
            // Gate and select rise together; the lanes follow a phase later
            if (phase_end) begin
               ctl_d.chip_sel_n = 1'b1;
               ctl_d.out_gate_n = 1'b1;
               tmr_load  = 1'b1;
               tmr_count = 4'(TURN_C);
               state_d   = ST_TURN;
            end
         end
         ST_WSETUP: begin
            if (phase_end) begin
               ctl_d.write_n = 1'b0;
               drive_n_d = {ctl_q.high_byte_lane_n,
                            ctl_q.low_byte_lane_n};
               tmr_load  = 1'b1;
               tmr_count = 4'(WLOW_C);
               state_d   = ST_WLOW;
            end
         end
         ST_WLOW: begin
            if (phase_end) begin
               // Strobe rise ends the write; data stays driven
               ctl_d.write_n = 1'b1;
               state_d       = ST_WEND;
            end
         end
         ST_WEND: begin
            // One cycle of data hold past the ending edge
            drive_n_d        = `IDLE_PINS_N;
            ctl_d.chip_sel_n = 1'b1;
            tmr_load  = 1'b1;
            tmr_count = 4'h1;
            state_d   = ST_TURN;
         end
         ST_TURN: begin
            // Lanes stay low until the float delay has surely run out
            if (phase_end) begin
               ctl_d.high_byte_lane_n = 1'b1;
               ctl_d.low_byte_lane_n  = 1'b1;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Read data sampled after the synchroniser delay, flag with it
   wire         rd_take  = in_read && phase_end;
   wire         wr_take  = in_wend;
   wire [1:0]   lane_on  = ~{ctl_q.high_byte_lane_n, ctl_q.low_byte_lane_n};
   logic [15:0] lane_mask;
   // A disabled lane floats at the memory, so it reads back as zero
   for (genvar g = 0; g < 2; g++) begin : g_lane
      assign lane_mask[8*g +: 8] = {8{lane_on[g]}};
   end
   wire [15:0]  rd_masked = dq_s2_q & lane_mask;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q   <= ST_IDLE;
         ctl_q     <= CTL_IDLE;
         drive_n_q <= `IDLE_PINS_N;
      end else begin
         state_q   <= state_d;
         ctl_q     <= ctl_d;
         drive_n_q <= drive_n_d;
      end
   end

   // Write data is held from acceptance until the next request
   always_ff @(posedge core_clk) begin
      if (reset) wdata_q <= 16'h0000;
      else if (accept) wdata_q <= req.wdata;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rsp_valid_q <= 1'b0;
         wr_done_q   <= 1'b0;
      end else begin
         rsp_valid_q <= rd_take;
         wr_done_q   <= wr_take;
      end
   end

   // The result stands until the next read completes
   always_ff @(posedge core_clk) begin
      if (reset) rsp_q <= '0;
      else if (rd_take) begin
         rsp_q.rdata     <= rd_masked;
         rsp_q.corrected <= flag_s2_q;
      end
   end

   // Pins come straight from registers, so no glitch reaches the memory
   assign ctl       = ctl_q;
   assign dq_out    = wdata_q;
   assign dq_oe_n   = drive_n_q;
   assign rsp       = rsp_q;
   assign rsp_valid = rsp_valid_q;
   assign wr_done   = wr_done_q;
endmodule

//--- sram_host_monitor.sv
// Pin-level checker for the SRAM host controller
`timescale 1ns/100ps
module sram_host_monitor import sram_host_pkg::*; #(
   parameter int ADDR_W = 18, // Word address width
   parameter int DATA_W = 16  // Data bus width
) (
   input wire logic        core_clk,  // Clock
   input wire logic        reset,     // Sync reset
   input wire logic        req_valid, // Request present
   input wire logic        req_ready, // Request taken
   input wire sram_req_t   req,       // Request
   input wire logic        rsp_valid, // Read done
   input wire sram_rsp_t   rsp,       // Read result
   input wire logic        wr_done,   // Write done
   input wire sram_ctl_t   ctl,       // Control pins
   input wire logic [15:0] dq_in,     // Data in
   input wire logic [15:0] dq_out,    // Data out
   input wire logic [1:0]  dq_oe_n,   // Lane enables
   input wire logic        flag_in    // Flag pin
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire       take  = req_valid && req_ready;
   wire [1:0] lanes = {ctl.high_byte_lane_n, ctl.low_byte_lane_n};
   property p_float; ctl.chip_sel_n |-> dq_oe_n == 2'h3; endproperty
   a_float: assert property (p_float) else $error("pins driven");
   property p_clash; dq_oe_n != 2'h3 |-> ctl.out_gate_n; endproperty
   a_clash: assert property (p_clash) else $error("bus clash");
   property p_rdwe; !ctl.chip_sel_n && !ctl.out_gate_n |-> ctl.write_n;
   endproperty
   a_rdwe: assert property (p_rdwe) else $error("strobe in read");
   property p_addr;
      !ctl.chip_sel_n && !$past(ctl.chip_sel_n) |-> $stable(ctl.addr);
   endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_hold; $rose(ctl.write_n) |-> $stable({dq_oe_n, dq_out});
   endproperty
   a_hold: assert property (p_hold) else $error("data not held");
   property p_lane; !ctl.write_n |-> dq_oe_n == lanes && !ctl.chip_sel_n;
   endproperty
   a_lane: assert property (p_lane) else $error("lane mismatch");
   property p_rd; take && !req.write |-> ##[4:12] rsp_valid; endproperty
   a_rd: assert property (p_rd) else $error("no read result");
   property p_wr; take && req.write |-> ##[4:12] wr_done; endproperty
   a_wr: assert property (p_wr) else $error("no write end");
   property p_busy; take |=> !req_ready [*3]; endproperty
   a_busy: assert property (p_busy) else $error("taken while busy");
   c_fix: cover property (rsp_valid && rsp.corrected);
   c_wr: cover property (wr_done);
   c_byte: cover property (!ctl.write_n && lanes == 2'h2);
endmodule
bind sram_host sram_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
   .core_clk(core_clk), .reset(reset), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
   .wr_done(wr_done), .ctl(ctl), .dq_in(dq_in), .dq_out(dq_out),
   .dq_oe_n(dq_oe_n), .flag_in(flag_in));

//--- sram_ecc_model.sv
// Behavioural ECC SRAM answering the host pins
`timescale 1ns/100ps
module sram_ecc_model import sram_host_pkg::*; (
   input  wire logic        core_clk, // Paces the float pattern only
   input  wire sram_ctl_t   ctl,      // Control pins
   input  wire logic [15:0] dq_out,   // Host data
   input  wire logic [1:0]  dq_oe_n,  // Host lane enables
   input  wire logic        inject,   // Report a corrected error
   output logic [15:0]      dq_in,    // Data pins
   output logic             flag_in   // Corrected flag
);
   logic [15:0] mem [int];
   logic [15:0] rd;
   logic        tog = 1'h0;
   wire  [1:0]  en_n  = {ctl.high_byte_lane_n, ctl.low_byte_lane_n};
   wire         rd_on = !ctl.chip_sel_n && !ctl.out_gate_n && ctl.write_n;
   wire  [1:0]  drv   = {2{rd_on}} & ~en_n;
   wire         wr_on = !ctl.chip_sel_n && !ctl.write_n && en_n != 2'h3;
   always @(posedge core_clk) tog <= ~tog;
   always @(ctl, tog) rd = mem.exists(ctl.addr) ? mem[ctl.addr] : 16'h0;
   // Floating pins toggle so a stale value never passes for read data
   assign dq_in = {drv[1] ? rd[15:8] : {8{tog}},
                   drv[0] ? rd[7:0] : {8{~tog}}};
   assign flag_in = |drv ? inject : tog;
   always @(negedge wr_on) begin
      logic [15:0] w;
      w = mem.exists(ctl.addr) ? mem[ctl.addr] : 16'h0;
      if (!en_n[0]) w[7:0] = dq_oe_n[0] ? {8{tog}} : dq_out[7:0];
      if (!en_n[1]) w[15:8] = dq_oe_n[1] ? {8{tog}} : dq_out[15:8];
      mem[ctl.addr] = w;
   end
endmodule

//--- test_sram_host.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/100ps
module test_sram_host;
   import sram_host_pkg::*;
   logic        core_clk = 1'h0, reset = 1'h1, req_valid = 1'h0;
   logic        inject = 1'h0, req_ready, rsp_valid, wr_done, flag_in;
   sram_req_t   req = '0;
   sram_rsp_t   rsp, got;
   sram_ctl_t   ctl;
   logic [15:0] dq_in, dq_out;
   logic [1:0]  dq_oe_n;
   int          errors = 0, num_checks = 0, cyc = 0, lat;
   // Row: write, lane_n, addr, wdata, inject, expected rdata and flag
   logic [54:0] rows [9] = '{
      {1'h1, 2'h0, 18'h00001, 16'hA5C3, 1'h0, 17'h0},
      {1'h0, 2'h0, 18'h00001, 16'h0, 1'h0, 16'hA5C3, 1'h0},
      {1'h1, 2'h2, 18'h00001, 16'h1E11, 1'h0, 17'h0},
      {1'h0, 2'h1, 18'h00001, 16'h0, 1'h1, 16'hA500, 1'h1},
      {1'h0, 2'h2, 18'h00001, 16'h0, 1'h0, 16'h0011, 1'h0},
      {1'h1, 2'h0, 18'h3FFFF, 16'h5A96, 1'h0, 17'h0},
      {1'h0, 2'h0, 18'h3FFFF, 16'h0, 1'h1, 16'h5A96, 1'h1},
      {1'h1, 2'h3, 18'h00001, 16'hFFFF, 1'h0, 17'h0},
      {1'h0, 2'h0, 18'h00001, 16'h0, 1'h0, 16'hA511, 1'h0}};
   sram_host u_sram_host (.core_clk(core_clk), .reset(reset),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp), .wr_done(wr_done), .ctl(ctl),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .flag_in(flag_in));
   sram_ecc_model u_sram_ecc_model (.core_clk(core_clk), .ctl(ctl),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .inject(inject), .dq_in(dq_in),
      .flag_in(flag_in));
   always #10 core_clk = ~core_clk;
   task conclude;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [24:0] e, input logic [24:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic do_req(input logic [54:0] r);
      @(negedge core_clk);
      req_valid = 1'h1;
      {req, inject} = r[54:17];
      while (req_ready !== 1'h1) @(negedge core_clk);
      @(negedge core_clk);
      req_valid = 1'h0;
      // Counted to the edge that samples the pulse, as the checker does
      lat = 1;
      while (rsp_valid !== 1'h1 && wr_done !== 1'h1 && lat < 20) begin
         @(posedge core_clk);
         #1 lat++;
      end
      got = rsp;
   endtask
   // Ceiling well above eleven transfers of at most twelve cycles each
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(negedge core_clk);
      reset = 1'h0;
      chk("reset_pins", {dq_oe_n, ctl}, {2'h3, 5'h1F, 18'h0});
      foreach (rows[i]) begin
         do_req(rows[i]);
         chk("latency", 1'h1, lat inside {[4:12]});
         if (!rows[i][54]) chk("read", rows[i][16:0], got);
      end
      // Reset in mid-read must drop every pin back to idle within two clock edges
      @(negedge core_clk);
      req_valid = 1'h1;
      req = rows[1][54:18];
      while (req_ready !== 1'h1) @(negedge core_clk);
      @(negedge core_clk);
      req_valid = 1'h0;
      chk("mid_read", 1'h0, ctl.chip_sel_n);
      reset = 1'h1;
      repeat (2) @(negedge core_clk);
      chk("mid_reset", {dq_oe_n, ctl}, {2'h3, 5'h1F, 18'h0});
      chk("reset_rsp", rsp, 17'h0);
      reset = 1'h0;
      do_req(rows[8]);
      chk("after_reset", rows[8][16:0], got);
      conclude();
   end
endmodule
